// [adcs_serial_if.sv]
// Serial output interface and conversion-cycle control of the converter
//
// What this block does
// [R1] Internal oscillator: convert 133 ms select low, 160 ms high, 147 ms variant.
// [R2] External conversion clock: one conversion takes 20510 of its cycles.
// [R3] Sleep until serial clock rises with chip select low, then output data.
// [R4] Internal serial clock is the conversion clock divided by 8, driven out.
// [R5] Internal clock: output lasts while select low, at most 32 serial clocks.
// [R6] External conversion clock with internal serial clock: at most 256 periods.
// [R7] External serial clock: output lasts while select low, at most 32 clocks.
// [R8] Each result bit is shifted out at a serial clock falling edge.
// [R9] Clock mode taken at power-up and every select fall: high internal.
// [R10] Internal mode drives the clock pin; external mode the host drives it.
// [R11] Output state sends the previous result serially, most significant first.
// [R12] Chip select high puts the data output into high impedance.
// [R13] Select low in convert or sleep shows done flag: high busy, low done.
// [R14] Select rising during output aborts transfer and starts a new conversion.
// [R15] Select held low gives continuous conversion at the full rate.
// [R16] Four modes: external or internal clock, single cycle or two-wire.
// [R17] External conversion clock of 2560 Hz or more replaces the oscillator.
// [R18] Frame: done flag, zero dummy, sign, 24-bit result, five sub-LSB bits.
// [R19] After the 32nd falling edge (external clock) or the 32nd rising edge (internal clock) the data output goes high.
// [R20] With select high, external clock pulses do not touch the shift register.
// [R21] Host samples on rising edges, 32 of them per frame.
// [R22] Result captured as done flag falls and held unchanged through sleep.
`timescale 1ns/1ns
module adcs_serial_if
  import adcs_pkg::*;
#(
  parameter logic [31:0] CONV_60_CYC = 32'(CONV_60_NS / CLK_NS),
  parameter logic [31:0] CONV_50_CYC = 32'(CONV_50_NS / CLK_NS),
  parameter logic [31:0] CONV_SIM_CYC = 32'(CONV_SIM_NS / CLK_NS),
  parameter logic [31:0] EXT_DET_CYC = 32'(EXT_DET_NS / CLK_NS),
  parameter int unsigned DEPTH = FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic cs_n,
  input wire logic sck_i,
  output logic sck_o,
  output logic sck_oe,
  output logic sdo_o,
  output logic sdo_oe,
  input wire logic rejection_select,
  input wire logic variant_simul,
  input wire logic res_valid,
  output logic res_ready,
  input wire adcs_result_t res_data,
  output logic sck_mode_internal,
  output logic ext_clock_present,
  output adcs_state_t state
);

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  localparam int unsigned RW = $bits(adcs_result_t);

  adcs_state_t st;
  adcs_state_t next_st;
  adcs_frame_t frame;
  logic [RW-1:0] fifo_q;
  logic fifo_valid;
  logic ctick;
  logic int_mode;
  logic mode_init;
  logic cs_q;
  logic sck_q;
  logic cs_fall;
  logic ext_rise;
  logic ext_fall;
  logic half_end;
  logic int_rise;
  logic rise;
  logic fall;
  logic step;
  logic conv_done;
  logic [1:0] half_cnt;
  logic [5:0] bit_cnt;
  logic [31:0] conv_cnt;
  logic [31:0] conv_lim;

  // ----------------------------------------
  // Submodules
  // ----------------------------------------
  adcs_fifo #(
    .WIDTH(RW),
    .DEPTH(DEPTH)
  ) u_fifo (
    .clk(clk),
    .rst_n(rst_n),
    .in_valid(res_valid),
    .in_ready(res_ready),
    .in_data(res_data),
    .out_valid(fifo_valid),
    .out_ready(conv_done),
    .out_data(fifo_q)
  );

  adcs_clk_src #(
    .DET_CYC(EXT_DET_CYC)
  ) u_clk_src (
    .clk(clk),
    .rst_n(rst_n),
    .rejection_select(rejection_select),
    .variant_simul(variant_simul),
    .ctick(ctick),
    .ext_present(ext_clock_present)
  );

  // ----------------------------------------
  // Pin edges
  // ----------------------------------------
  assign cs_fall = cs_q & ~cs_n;
  assign ext_rise = ~int_mode & ~cs_n & sck_i & ~sck_q; // R20
  assign ext_fall = ~int_mode & ~cs_n & ~sck_i & sck_q; // R20
  assign half_end = int_mode & ~cs_n & ~cs_fall & ctick & (half_cnt == HALF_LAST)
                    & (st != ST_CONV);
  assign int_rise = half_end & ~sck_o;
  assign rise = ext_rise | int_rise;
  assign fall = ext_fall | (half_end & sck_o);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cs_q <= 1'b1;
      sck_q <= 1'b1;
    end else begin
      cs_q <= cs_n;
      sck_q <= sck_i;
    end
  end

  // ----------------------------------------
  // Serial clock mode
  // ----------------------------------------
  // The level on the clock pin is caught on the first edge after reset.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      int_mode <= MODE_INTERNAL;
      mode_init <= 1'b0;
    end else if (!mode_init || cs_fall) begin
      int_mode <= sck_i; // R9 R16
      mode_init <= 1'b1;
    end
  end

  assign sck_mode_internal = int_mode;

  // ----------------------------------------
  // Conversion timer
  // ----------------------------------------
  always_comb begin
    if (ext_clock_present) begin
      conv_lim = 32'(EXT_CONV_TICKS) - 32'h1; // R2
    end else if (variant_simul) begin
      conv_lim = CONV_SIM_CYC - 32'h1; // R1
    end else if (rejection_select) begin
      conv_lim = CONV_50_CYC - 32'h1; // R1
    end else begin
      conv_lim = CONV_60_CYC - 32'h1; // R1
    end
  end

  assign step = ext_clock_present ? ctick : 1'b1;
  // A result missing from the FIFO stretches the conversion
  assign conv_done = (st == ST_CONV) && (conv_cnt >= conv_lim) && fifo_valid;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      conv_cnt <= '0;
    end else if (st != ST_CONV) begin
      conv_cnt <= '0;
    end else if (step && conv_cnt < conv_lim) begin
      conv_cnt <= conv_cnt + 32'h1; // R1 R2
    end
  end

  // ----------------------------------------
  // State machine
  // ----------------------------------------
  always_comb begin
    next_st = st;
    unique case (st)
      ST_CONV: begin
        if (conv_done) begin
          next_st = ST_SLEEP;
        end
      end
      ST_SLEEP: begin
        if (rise) begin
          next_st = ST_DOUT; // R3 R15
        end
      end
      ST_DOUT: begin
        if (cs_n) begin
          next_st = ST_CONV; // R14
        end else if (int_mode && int_rise && bit_cnt == CNT_PRE_LAST) begin
          next_st = ST_CONV; // R5 R6
        end else if (!int_mode && ext_fall && bit_cnt == CNT_LAST) begin
          next_st = ST_CONV; // R7 R19
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st <= ST_CONV;
      state <= ST_CONV;
    end else begin
      st <= next_st;
      state <= next_st;
    end
  end

  // ----------------------------------------
  // Internal serial clock
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      half_cnt <= '0;
    end else if (st == ST_CONV || cs_n || !int_mode) begin
      half_cnt <= '0;
    end else if (ctick) begin
      half_cnt <= half_cnt + 2'h1; // R4
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sck_o <= 1'b1;
      sck_oe <= 1'b0;
    end else begin
      // No drive before the power-up mode has been taken from the pin
      sck_oe <= int_mode & mode_init & ~cs_n & ~cs_fall; // R10
      if (cs_fall) begin
        sck_o <= 1'b0;
      end else if (half_end) begin
        sck_o <= ~sck_o; // R4
      end
    end
  end

  // ----------------------------------------
  // Rising edge count
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      bit_cnt <= '0;
    end else if (next_st != ST_DOUT) begin
      bit_cnt <= '0;
    end else if (rise) begin
      bit_cnt <= bit_cnt + 6'h01; // R5 R7
    end
  end

  // ----------------------------------------
  // Output shift register
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      frame <= '0;
    end else if (conv_done) begin
      frame.eoc_n <= 1'b0; // R18 R22
      frame.dummy_frame_bit <= 1'b0; // R18
      frame.result <= adcs_result_t'(fifo_q); // R18 R22
    end else if (st == ST_DOUT && next_st == ST_DOUT && fall) begin
      frame <= adcs_frame_t'({frame[FRAME_BITS-2:0], 1'b1}); // R8 R11
    end
  end

  // ----------------------------------------
  // Data output pin
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sdo_o <= 1'b1;
      sdo_oe <= 1'b0;
    end else begin
      sdo_oe <= ~cs_n; // R12
      if (next_st == ST_CONV) begin
        sdo_o <= 1'b1; // R13 R19
      end else if (next_st == ST_SLEEP) begin
        sdo_o <= 1'b0; // R13
      end else if (fall) begin
        sdo_o <= frame[FRAME_BITS-2]; // R8 R11
      end
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking dcb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  a_sdo_hiz_cs: assert property (cs_n |=> !sdo_oe) // R12
    else $error("data output driven with chip select high");
  a_eoc_busy: assert property (!cs_n && st == ST_CONV && !conv_done |=> sdo_o && sdo_oe) // R13
    else $error("done flag not high during conversion");
  a_eoc_done: assert property (!cs_n && st == ST_SLEEP && !rise |=> !sdo_o && sdo_oe) // R13
    else $error("done flag not low during sleep");
  a_abort_cs: assert property (st == ST_DOUT && cs_n |=> st == ST_CONV && sdo_o) // R14
    else $error("chip select rise did not abort output");
  a_sleep_exit: assert property (st == ST_SLEEP && rise |=> st == ST_DOUT && bit_cnt == 6'h01) // R3
    else $error("sleep not left on first rising edge");
  a_ext_end: assert property (st == ST_DOUT && ext_fall && bit_cnt == CNT_LAST
                              |=> st == ST_CONV && sdo_o) // R19
    else $error("frame end after last falling edge wrong");
  a_int_end: assert property (st == ST_DOUT && int_rise && bit_cnt == CNT_PRE_LAST
                              |=> st == ST_CONV && sck_o) // R5
    else $error("internal frame not ended at last rising edge");
  a_bits_max: assert property (bit_cnt <= CNT_LAST) // R7
    else $error("more than 32 rising edges counted");
  a_sck_div: assert property ($rose(sck_o) |-> $past(half_cnt) == HALF_LAST && $past(ctick)) // R4
    else $error("internal serial clock not divided by 8");
  a_sck_dir: assert property (sck_oe |-> int_mode && !$past(cs_n)) // R10
    else $error("clock pin driven outside internal mode");
  a_frame_load: assert property (conv_done |=> frame[FRAME_BITS-1 -: 2] == 2'b00
                                 && frame.result == $past(fifo_q)) // R18
    else $error("frame not loaded at end of conversion");
  a_sleep_hold: assert property (st == ST_SLEEP |=> $stable(frame)) // R22
    else $error("result changed during sleep");
  a_shift_msb: assert property (st == ST_DOUT && fall && next_st == ST_DOUT
                                |=> sdo_o == $past(frame[FRAME_BITS-2])) // R8
    else $error("wrong bit shifted out on falling edge");
  a_conv_bound: assert property (st == ST_CONV |-> conv_cnt <= conv_lim || !step) // R1
    else $error("conversion counter passed its limit");
  a_mode_sel: assert property (cs_fall |=> int_mode == $past(sck_i)) // R9
    else $error("clock mode not taken at chip select fall");
  a_sck_park: assert property (cs_fall |=> !sck_o) // R4
    else $error("serial clock not parked low at chip select fall");
  a_cs_idle: assert property (cs_n && st != ST_CONV
                              |=> $stable(frame) && bit_cnt == '0) // R20
    else $error("shift register moved with chip select high");
  a_sleep_stay: assert property (st == ST_SLEEP |=> st != ST_CONV) // R3
    else $error("sleep left without a serial clock edge");

  c_ext_frame: cover property (st == ST_DOUT && ext_fall && bit_cnt == CNT_LAST);
  c_int_frame: cover property (st == ST_DOUT && int_rise && bit_cnt == CNT_PRE_LAST);
  c_abort: cover property (st == ST_DOUT && cs_n);
  c_ext_clock: cover property ($rose(ext_clock_present));
  c_int_start: cover property (st == ST_SLEEP && int_rise);

endmodule

// [adcs_pkg.sv]
// Constants and types shared by the serial conversion interface
package adcs_pkg;

  // ----------------------------------------
  // Clock and timing
  // ----------------------------------------
  localparam int unsigned CLK_NS = 10;
  localparam int unsigned CONV_60_NS = 133_000_000;
  localparam int unsigned CONV_50_NS = 160_000_000;
  localparam int unsigned CONV_SIM_NS = 147_000_000;
  localparam int unsigned EXT_CONV_TICKS = 20510;
  localparam int unsigned SCK_DIV = 8;
  localparam int unsigned FRAME_BITS = 32;
  localparam int unsigned DOUT_INT_NS = 1_670_000;
  localparam int unsigned DOUT_SIM_NS = 1_830_000;
  localparam int unsigned TICK_INT_CYC = DOUT_INT_NS / (CLK_NS * SCK_DIV * FRAME_BITS);
  localparam int unsigned TICK_SIM_CYC = DOUT_SIM_NS / (CLK_NS * SCK_DIV * FRAME_BITS);
  localparam int unsigned EXT_MIN_HZ = 2560;
  localparam int unsigned EXT_DET_NS = 1_000_000_000 / EXT_MIN_HZ;
  localparam int unsigned FIFO_DEPTH = 16;

  // ----------------------------------------
  // Counter limits and reset values
  // ----------------------------------------
  localparam logic [5:0] CNT_LAST = 6'h20;
  localparam logic [5:0] CNT_PRE_LAST = 6'h1f;
  localparam logic [1:0] HALF_LAST = 2'h3;
  localparam logic MODE_INTERNAL = 1'b1;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef struct packed {
    logic sign_bit;
    logic [23:0] magnitude;
    logic [4:0] sub_lsb;
  } adcs_result_t;

  typedef struct packed {
    logic eoc_n;
    logic dummy_frame_bit;
    adcs_result_t result;
  } adcs_frame_t;

  typedef enum logic [2:0] {
    ST_CONV = 3'b001,
    ST_SLEEP = 3'b010,
    ST_DOUT = 3'b100
  } adcs_state_t;

endpackage

// [adcs_fifo.sv]
// Result FIFO between the modulator and the output shift register
`timescale 1ns/1ns
module adcs_fifo #(
  parameter int unsigned WIDTH = 30,
  parameter int unsigned DEPTH = 16
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int unsigned AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic [AW:0] next_count;
  logic push;
  logic pop;

  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;
  assign out_valid = (count != '0);
  assign out_data = mem[rd_ptr];

  always_comb begin
    next_count = count;
    if (push && !pop) begin
      next_count = count + 1'b1;
    end else if (pop && !push) begin
      next_count = count - 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
      in_ready <= 1'b1;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      count <= next_count;
      in_ready <= (next_count != FULL_CNT);
    end
  end
endmodule

// [adcs_clk_src.sv]
// Conversion clock source: internal oscillator or external clock detect
`timescale 1ns/1ns
module adcs_clk_src
  import adcs_pkg::*;
#(
  parameter logic [31:0] DET_CYC = 32'(EXT_DET_NS / CLK_NS),
  parameter logic [15:0] TICK_A = 16'(TICK_INT_CYC),
  parameter logic [15:0] TICK_B = 16'(TICK_SIM_CYC)
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic rejection_select,
  input wire logic variant_simul,
  output logic ctick,
  output logic ext_present
);
  logic rs_q;
  logic rs_rise;
  logic recent;
  logic [31:0] det_cnt;
  logic [15:0] int_cnt;
  logic [15:0] tick_lim;

  assign rs_rise = rejection_select & ~rs_q;
  assign tick_lim = variant_simul ? TICK_B - 16'h0001 : TICK_A - 16'h0001;

  // ----------------------------------------
  // External clock detect
  // ----------------------------------------
  // Two rising edges within the window are needed, so a mere level change
  // of the select input is not taken for a clock.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rs_q <= 1'b0;
      recent <= 1'b0;
      det_cnt <= '0;
      ext_present <= 1'b0;
    end else begin
      rs_q <= rejection_select;
      if (rs_rise) begin
        ext_present <= recent; // R17
        recent <= 1'b1;
        det_cnt <= '0;
      end else if (det_cnt >= DET_CYC - 32'h1) begin
        recent <= 1'b0;
        ext_present <= 1'b0; // R17
      end else begin
        det_cnt <= det_cnt + 32'h1;
      end
    end
  end

  // ----------------------------------------
  // Conversion clock tick
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      int_cnt <= '0;
      ctick <= 1'b0;
    end else begin
      if (ext_present || int_cnt >= tick_lim) begin
        int_cnt <= '0; // R17
      end else begin
        int_cnt <= int_cnt + 16'h0001;
      end
      ctick <= ext_present ? rs_rise : (int_cnt >= tick_lim); // R6
    end
  end
endmodule

// [adcs_host_model.sv]
// Host controller model: chip select, serial clock and frame capture
`timescale 1ns/1ns
module adcs_host_model (
  input wire logic clk,
  input wire logic sdo,
  output logic cs_n,
  output logic sck_drv,
  output logic sck_en,
  output logic frame_done,
  output logic [31:0] frame
);
  initial begin
    cs_n = 1'b1;
    sck_drv = 1'b0;
    sck_en = 1'b1;
    frame_done = 1'b0;
    frame = 32'h0;
  end

  // Drive the clock pin low for external mode, release it for internal
  task automatic select(input logic ext);
    @(negedge clk);
    sck_en = ext;
    repeat (2) @(negedge clk);
    cs_n = 1'b0;
  endtask

  task automatic deselect();
    @(negedge clk);
    cs_n = 1'b1;
  endtask

  // Each level held for hold clocks, data taken as the clock rises
  task automatic clock_bits(input int n, input int hold);
    for (int i = 0; i < n; i++) begin
      repeat (hold) @(negedge clk);
      sck_drv = 1'b1;
      frame = {frame[30:0], sdo};
      repeat (hold) @(negedge clk);
      sck_drv = 1'b0;
    end
    if (n == 32) begin
      frame_done = 1'b1;
      @(negedge clk);
      frame_done = 1'b0;
    end
  endtask
endmodule

// [tb_adc_serial_conversion_interface.sv]
// Self-checking testbench of the serial conversion interface
`timescale 1ns/1ns
module tb_adc_serial_conversion_interface;
  import adcs_pkg::*;
  localparam int C60 = 200;
  localparam int C50 = 260;
  localparam int CSIM = 230;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic rejection_select = 1'b0;
  logic variant_simul = 1'b0;
  logic res_valid = 1'b0;
  adcs_result_t res_data = '0;
  logic sck_o, sck_oe, sdo_o, sdo_oe, res_ready, sck_mode_internal, ext_clock_present;
  adcs_state_t state;
  logic cs_n, sck_drv, sck_en, frame_done;
  logic sdo_hold = 1'b0;
  logic [31:0] frame;
  logic [31:0] seed = 32'h0001022f;
  logic [31:0] exp_q[$];
  adcs_result_t word_q[$];
  int n_errors = 0;
  int total_checks = 0;
  int cyc[3] = '{C60, C50, CSIM};
  // Clock pin pulled high when nobody drives it
  wire sck_pin = sck_oe ? sck_o : (sck_en ? sck_drv : 1'b1);
  wire sdo_pin = sdo_oe ? sdo_o : ~sdo_hold;

  always #5 clk = ~clk;
  always @(posedge clk) if (sdo_oe) sdo_hold <= sdo_o;

  adcs_serial_if #(.CONV_60_CYC(32'(C60)), .CONV_50_CYC(32'(C50)),
    .CONV_SIM_CYC(32'(CSIM)), .EXT_DET_CYC(32'h40), .DEPTH(16)) dut (
    .clk(clk), .rst_n(rst_n), .cs_n(cs_n), .sck_i(sck_pin), .sck_o(sck_o),
    .sck_oe(sck_oe), .sdo_o(sdo_o), .sdo_oe(sdo_oe),
    .rejection_select(rejection_select), .variant_simul(variant_simul),
    .res_valid(res_valid), .res_ready(res_ready), .res_data(res_data),
    .sck_mode_internal(sck_mode_internal), .ext_clock_present(ext_clock_present),
    .state(state));

  adcs_host_model host (.clk(clk), .sdo(sdo_pin), .cs_n(cs_n), .sck_drv(sck_drv),
    .sck_en(sck_en), .frame_done(frame_done), .frame(frame));

  // ---------------------------------
  // Helpers
  // ---------------------------------
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  task automatic stop_test();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] %s exp %h got %h", nm, e, g);
    end
  endtask

  task automatic chk_rng(input string nm, input int lo, input int hi, input int g);
    total_checks++;
    if (g < lo || g > hi) begin
      n_errors++;
      $display("[FAIL] %s exp %0d..%0d got %0d", nm, lo, hi, g);
    end
  endtask

  task automatic bound(input string nm, input int n, input int lim);
    if (n >= lim) begin
      n_errors++;
      $display("[FAIL] %s exp done got timeout", nm);
      stop_test();
    end
  endtask

  task automatic wait_st(input adcs_state_t s, output int n);
    n = 0;
    while (state !== s && n < 3000) begin
      @(negedge clk);
      n++;
    end
    bound("state wait", n, 3000);
  endtask

  task automatic push();
    int n;
    seed = xs(seed);
    word_q.push_back(seed[29:0]);
    res_data = seed[29:0];
    res_valid = 1'b1;
    n = 0;
    while (res_ready !== 1'b1 && n < 3000) begin
      @(negedge clk);
      n++;
    end
    bound("push", n, 3000);
    @(negedge clk);
  endtask

  task automatic read(input int hold);
    exp_q.push_back({2'b00, word_q.pop_front()});
    host.clock_bits(32, hold);
  endtask

  always @(posedge clk) begin
    if (frame_done === 1'b1) chk("frame", exp_q.pop_front(), frame);
  end

  // ---------------------------------
  // Main sequence
  // ---------------------------------
  initial begin
    int n;
    repeat (3) @(negedge clk);
    chk("sdo_oe", 0, sdo_oe);
    chk("sck_oe", 0, sck_oe);
    chk("state", ST_CONV, state);
    rst_n = 1'b1;
    for (int i = 0; i < 16; i++) push();
    res_valid = 1'b0;
    @(negedge clk);
    chk("res_ready", 0, res_ready);
    push();
    res_valid = 1'b0;
    host.clock_bits(3, 2);
    host.select(1'b1);
    repeat (2) @(negedge clk);
    chk("state", ST_SLEEP, state);
    chk("sdo", 0, sdo_pin);
    chk("mode", 0, sck_mode_internal);
    for (int m = 0; m < 3; m++) begin
      rejection_select = (m == 1);
      variant_simul = (m == 2);
      read(2 + m);
      repeat (2) @(negedge clk);
      chk("sdo", 1, sdo_pin);
      chk("state", ST_CONV, state);
      wait_st(ST_SLEEP, n);
      chk_rng("conv", cyc[m] - 4, cyc[m] + 4, n + 2);
      chk("sdo", 0, sdo_pin);
    end
    rejection_select = 1'b0;
    variant_simul = 1'b0;
    void'(word_q.pop_front());
    host.clock_bits(5, 2);
    chk("state", ST_DOUT, state);
    host.deselect();
    repeat (2) @(negedge clk);
    chk("state", ST_CONV, state);
    chk("sdo_oe", 0, sdo_oe);
    wait_st(ST_SLEEP, n);
    host.select(1'b0);
    repeat (2) @(negedge clk);
    chk("sck_oe", 1, sck_oe);
    chk("sck_o", 0, sck_o);
    chk("mode", 1, sck_mode_internal);
    n = 0;
    while (sck_o !== 1'b1 && n < 4000) begin
      @(negedge clk);
      n++;
    end
    bound("sck rise", n, 4000);
    chk_rng("sck low", 3 * TICK_INT_CYC - 4, 4 * TICK_INT_CYC + 4, n);
    repeat (2) @(negedge clk);
    chk("state", ST_DOUT, state);
    void'(word_q.pop_front());
    host.deselect();
    repeat (2) @(negedge clk);
    chk("state", ST_CONV, state);
    chk("sck_oe", 0, sck_oe);
    host.select(1'b1);
    for (int i = 0; i < 12; i++) begin
      wait_st(ST_SLEEP, n);
      seed = xs(seed);
      read(2 + seed[1:0]);
    end
    repeat (3 * C60) @(negedge clk);
    chk("state", ST_CONV, state);
    push();
    res_valid = 1'b0;
    wait_st(ST_SLEEP, n);
    read(3);
    repeat (4) @(negedge clk);
    for (int i = 0; i < 40; i++) begin
      repeat (4) @(negedge clk);
      rejection_select = ~rejection_select;
    end
    chk("ext clk", 1, ext_clock_present);
    repeat (200) @(negedge clk);
    chk("ext clk", 0, ext_clock_present);
    chk("frames left", 0, exp_q.size());
    stop_test();
  end
endmodule
